// *** hw/aist_pkg.sv ***
package aist_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   // Groups of four words: plain, clear, set, invert; status and config are single words
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_COUNT = 8'h10;
   localparam logic [7:0] ADR_PERIOD = 8'h20;
   localparam logic [7:0] ADR_MASK = 8'h30;
   localparam logic [7:0] ADR_STAT = 8'h40;
   localparam logic [7:0] ADR_CFG = 8'h44;

   // Companion selector in address bits 3:2
   localparam logic [1:0] OP_PLAIN = 2'h0;
   localparam logic [1:0] OP_CLR = 2'h1;
   localparam logic [1:0] OP_SET = 2'h2;
   localparam logic [1:0] OP_INV = 2'h3;

   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int CTRL_ON_BIT = 15;
   localparam int CTRL_STOP_IN_IDLE_BIT = 13;
   localparam int CTRL_WDIS_BIT = 12;
   localparam int CTRL_WIP_BIT = 11;
   localparam int CTRL_GATE_BIT = 7;
   localparam int CTRL_PS_LO = 4;
   localparam int CTRL_SYNC_BIT = 2;
   localparam int CTRL_TCS_BIT = 1;
   localparam logic [31:0] CTRL_WMASK = 32'h0000b0b6;
   localparam logic [31:0] CTRL_RST = 32'h00000000;

   // Counter, period, status, mask, config
   localparam int CNT_W = 16;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam int NSTAT = 2;
   localparam int STAT_TICK = 0;
   localparam int STAT_DROP = 1;
   localparam logic [NSTAT-1:0] STAT_RST = 2'h0;
   localparam int CFG_SOSC_BIT = 0;
   localparam logic [31:0] CFG_RST = 32'h00000000;

   // Prescale codes and terminal masks
   localparam logic [1:0] PS_1 = 2'h0;
   localparam logic [1:0] PS_8 = 2'h1;
   localparam logic [1:0] PS_64 = 2'h2;
   localparam logic [1:0] PS_256 = 2'h3;
   localparam logic [7:0] PS_MASK_1 = 8'h00;
   localparam logic [7:0] PS_MASK_8 = 8'h07;
   localparam logic [7:0] PS_MASK_64 = 8'h3f;
   localparam logic [7:0] PS_MASK_256 = 8'hff;

   // External edges a pending asynchronous count write must wait
   localparam int unsigned ASYNC_WR_EDGES = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic on;
      logic stop_in_idle;
      logic wdis;
      logic gate_en;
      logic [1:0] ps;
      logic sync;
      logic clock_source_select;
   } aist_ctrl_t;

   // Apply a plain, clear, set or invert write under a byte mask
   function automatic logic [31:0] apply_op(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [31:0] bm, input logic [1:0] op);
      logic [31:0] r;
      r = old;
      unique case (op)
         OP_PLAIN: r = (old & ~bm) | (wd & bm);
         OP_CLR: r = old & ~(wd & bm);
         OP_SET: r = old | (wd & bm);
         OP_INV: r = old ^ (wd & bm);
      endcase
      return r;
   endfunction

endpackage

// *** hw/aist_prescale.sv ***
`timescale 1ns/100ps
module aist_prescale #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic clear,
   input wire logic tick_in,
   input wire logic [1:0] sel,
   output logic tick_out
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] term;

   // ----------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------
   // Terminal mask per code; 1:1 passes every tick
   always_comb begin
      term = W'(aist_pkg::PS_MASK_1);
      unique case (sel)
         aist_pkg::PS_1: term = W'(aist_pkg::PS_MASK_1);
         aist_pkg::PS_8: term = W'(aist_pkg::PS_MASK_8);
         aist_pkg::PS_64: term = W'(aist_pkg::PS_MASK_64);
         aist_pkg::PS_256: term = W'(aist_pkg::PS_MASK_256);
      endcase
   end

   // Pulse output, combinational so the count step is not delayed
   assign tick_out = tick_in && ((cnt_r & term) == term);

   // Cleared while off so a restart begins a full prescale period
   always_ff @(posedge clock) begin
      if (rst || clear) begin
         cnt_r <= '0;
      end else if (tick_in) begin
         cnt_r <= tick_out ? '0 : cnt_r + W'(1);
      end
   end

endmodule

// *** hw/aist_timer.sv ***
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/100ps
module aist_timer (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_clk_pin,
   input wire logic sosc_clk_pin,
   input wire logic gate_pin,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   output logic irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam int NPIN = 3;
   localparam int P_EXT = 0;
   localparam int P_SOSC = 1;
   localparam int P_GATE = 2;

   logic [31:0] ctrl_r;
   logic [15:0] count_r;
   logic [15:0] period_r;
   logic [aist_pkg::NSTAT-1:0] stat_r;
   logic [aist_pkg::NSTAT-1:0] mask_r;
   logic [31:0] cfg_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic irq_r;
   logic pend_r;
   logic [15:0] pend_val_r;
   logic [1:0] pend_edges_r;

   logic [NPIN-1:0] pins;
   logic [NPIN-1:0] sync1_r;
   logic [NPIN-1:0] sync2_r;
   logic [NPIN-1:0] prev_r;
   logic [NPIN-1:0] rise;
   logic [NPIN-1:0] fall;

   aist_pkg::aist_ctrl_t ctl;
   logic async_mode;
   logic wip;
   logic req;
   logic wr;
   logic [31:0] bm;
   logic [1:0] op;
   logic [3:0] grp;
   logic wr_ctrl;
   logic wr_count;
   logic wr_period;
   logic wr_mask;
   logic wr_stat;
   logic wr_cfg;
   logic [31:0] count_new;
   logic ext_edge;
   logic tick_src;
   logic run;
   logic ptick;
   logic match;
   logic gate_fall_ev;
   logic drop_ev;
   logic pend_done;
   logic load_now;
   logic [15:0] load_val;
   logic [aist_pkg::NSTAT-1:0] ev;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   assign pins = {gate_pin, sosc_clk_pin, ext_clk_pin};

   // Two flops per pin, then an edge tap that reads only the second
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi++) begin : g_pin
         always_ff @(posedge clock) begin
            if (rst) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
               prev_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pins[gi];
               sync2_r[gi] <= sync1_r[gi];
               prev_r[gi] <= sync2_r[gi];
            end
         end
         assign rise[gi] = sync2_r[gi] && !prev_r[gi];
         assign fall[gi] = !sync2_r[gi] && prev_r[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Control decode
   // ----------------------------------------------------------------
   assign ctl.on = ctrl_r[aist_pkg::CTRL_ON_BIT];
   assign ctl.stop_in_idle = ctrl_r[aist_pkg::CTRL_STOP_IN_IDLE_BIT];
   assign ctl.wdis = ctrl_r[aist_pkg::CTRL_WDIS_BIT];
   assign ctl.gate_en = ctrl_r[aist_pkg::CTRL_GATE_BIT];
   assign ctl.ps = ctrl_r[aist_pkg::CTRL_PS_LO +: 2];
   assign ctl.sync = ctrl_r[aist_pkg::CTRL_SYNC_BIT];
   assign ctl.clock_source_select = ctrl_r[aist_pkg::CTRL_TCS_BIT];

   // External clock without sync runs the count asynchronously
   assign async_mode = ctl.clock_source_select && !ctl.sync;
   assign wip = pend_r && async_mode;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign req = wb_cyc_i && wb_stb_i && !ack_r;
   assign wr = req && wb_we_i;
   assign bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign op = wb_adr_i[3:2];
   assign grp = wb_adr_i[7:4];

   assign wr_ctrl = wr && (grp == aist_pkg::ADR_CTRL[7:4]);
   assign wr_count = wr && (grp == aist_pkg::ADR_COUNT[7:4]);
   assign wr_period = wr && (grp == aist_pkg::ADR_PERIOD[7:4]);
   assign wr_mask = wr && (grp == aist_pkg::ADR_MASK[7:4]);
   assign wr_stat = wr && (wb_adr_i == aist_pkg::ADR_STAT);
   assign wr_cfg = wr && (wb_adr_i == aist_pkg::ADR_CFG);

   // Companion op on the value software sees
   assign count_new = aist_pkg::apply_op({16'h0000, count_r}, wb_dat_i, bm, op);

   // One wait-free cycle: ack follows the taking edge
   always_ff @(posedge clock) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req;
      end
   end
   assign wb_ack_o = ack_r;

   // Read mux; unmapped words read zero but still ack
   always_comb begin
      rd_mux = 32'h00000000;
      if (grp == aist_pkg::ADR_CTRL[7:4]) begin
         rd_mux = ctrl_r;
         rd_mux[aist_pkg::CTRL_WIP_BIT] = wip;
      end else if (grp == aist_pkg::ADR_COUNT[7:4]) begin
         rd_mux = {16'h0000, count_r};
      end else if (grp == aist_pkg::ADR_PERIOD[7:4]) begin
         rd_mux = {16'h0000, period_r};
      end else if (grp == aist_pkg::ADR_MASK[7:4]) begin
         rd_mux = {{(32 - aist_pkg::NSTAT){1'b0}}, mask_r};
      end else if (wb_adr_i == aist_pkg::ADR_STAT) begin
         rd_mux = {{(32 - aist_pkg::NSTAT){1'b0}}, stat_r};
      end else if (wb_adr_i == aist_pkg::ADR_CFG) begin
         rd_mux = cfg_r;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdat_r <= 32'h00000000;
      end else if (req && !wb_we_i) begin
         rdat_r <= rd_mux;
      end
   end
   assign wb_dat_o = rdat_r;

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   // Only documented control bits are writable; the rest read zero except bit 11, the pending flag
   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl_r <= aist_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= aist_pkg::apply_op(ctrl_r, wb_dat_i, bm & aist_pkg::CTRL_WMASK, op);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         period_r <= aist_pkg::PERIOD_RST;
      end else if (wr_period) begin
         period_r <= 16'(aist_pkg::apply_op({16'h0000, period_r}, wb_dat_i, bm, op));
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         mask_r <= '0;
      end else if (wr_mask) begin
         mask_r <= aist_pkg::NSTAT'(aist_pkg::apply_op(32'(mask_r), wb_dat_i, bm, op));
      end
   end

   // Oscillator select for the external clock source, synchronised or not
   always_ff @(posedge clock) begin
      if (rst) begin
         cfg_r <= aist_pkg::CFG_RST;
      end else if (wr_cfg) begin
         cfg_r <= (cfg_r & ~(bm & 32'h00000001)) | (wb_dat_i & bm & 32'h00000001);
      end
   end

   // ----------------------------------------------------------------
   // Clock source and run condition
   // ----------------------------------------------------------------
   // Secondary oscillator only matters in the external modes
   assign ext_edge = cfg_r[aist_pkg::CFG_SOSC_BIT] ? rise[P_SOSC] : rise[P_EXT];

   // Gate bit ignored whenever the external source is chosen
   always_comb begin
      if (ctl.clock_source_select) begin
         tick_src = ext_edge;
      end else if (ctl.gate_en) begin
         tick_src = sync2_r[P_GATE];
      end else begin
         tick_src = 1'b1;
      end
   end

   // Sleep stops the bus clock modes; only asynchronous counting survives
   assign run = ctl.on && !(idle_mode && ctl.stop_in_idle) && !(sleep_mode && !async_mode);

   aist_prescale #(
      .W(8)
   ) u_prescale (
      .clock(clock),
      .rst(rst),
      .clear(!ctl.on),
      .tick_in(run && tick_src),
      .sel(ctl.ps),
      .tick_out(ptick)
   );

   assign match = ptick && (count_r == period_r);
   assign gate_fall_ev = ctl.on && !ctl.clock_source_select && ctl.gate_en && fall[P_GATE];

   // ----------------------------------------------------------------
   // Asynchronous write crossing
   // ----------------------------------------------------------------
   // Write lands after a set number of external edges, as in silicon
   assign drop_ev = wr_count && async_mode && pend_r && ctl.wdis;
   assign pend_done = pend_r && (!async_mode
                      || (ext_edge && (pend_edges_r == 2'(aist_pkg::ASYNC_WR_EDGES - 1))));

   always_ff @(posedge clock) begin
      if (rst) begin
         pend_r <= 1'b0;
         pend_val_r <= aist_pkg::COUNT_RST;
         pend_edges_r <= 2'h0;
      end else if (wr_count && async_mode && !drop_ev) begin
         pend_r <= 1'b1;
         pend_val_r <= count_new[15:0];
         pend_edges_r <= 2'h0;
      end else if (pend_done) begin
         pend_r <= 1'b0;
         pend_edges_r <= 2'h0;
      end else if (pend_r && ext_edge) begin
         pend_edges_r <= pend_edges_r + 2'h1;
      end
   end

   // Synchronous writes load at once; a completing async write loads late
   always_comb begin
      load_now = 1'b0;
      load_val = count_new[15:0];
      if (wr_count && !async_mode) begin
         load_now = 1'b1;
      end else if (pend_done) begin
         load_now = 1'b1;
         load_val = pend_val_r;
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Software load wins over a count step in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         count_r <= aist_pkg::COUNT_RST;
      end else if (load_now) begin
         count_r <= load_val;
      end else if (ptick) begin
         count_r <= match ? 16'h0000 : count_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and output
   // ----------------------------------------------------------------
   always_comb begin
      ev = '0;
      ev[aist_pkg::STAT_TICK] = match || gate_fall_ev;
      ev[aist_pkg::STAT_DROP] = drop_ev;
   end

   // Write one to clear; a new event in the same cycle stays set
   always_ff @(posedge clock) begin
      if (rst) begin
         stat_r <= aist_pkg::STAT_RST;
      end else if (wr_stat) begin
         stat_r <= (stat_r & ~aist_pkg::NSTAT'(wb_dat_i & bm)) | ev;
      end else begin
         stat_r <= stat_r | ev;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & mask_r);
      end
   end
   assign irq = irq_r;

endmodule

// *** test/aist_clk_src.sv ***
`timescale 1ns/100ps
module aist_clk_src #(
   parameter int HALF = 3
) (
   input wire logic clock,
   input wire logic run,
   output logic pin
);
   int n = 0;
   initial pin = 1'b0;
   // Free clock source; stands still while not running, so no stray edges
   always @(posedge clock) begin
      if (run) begin
         n = n + 1;
         if (n >= HALF) begin
            n = 0;
            pin <= ~pin;
         end
      end
   end
endmodule

// *** test/aist_timer_props.sv ***
`timescale 1ns/100ps
module aist_timer_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ext_clk_pin,
   input wire logic sosc_clk_pin,
   input wire logic gate_pin,
   input wire logic idle_mode,
   input wire logic sleep_mode,
   input wire logic irq
);
   // ----------------
   // Bus and interrupt
   // ----------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Master holds the address during ack, so decode needs no history
   logic ctrl_rd;
   logic hole_rd;
   assign ctrl_rd = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00;
   assign hole_rd = wb_ack_o && !wb_we_i && wb_adr_i[7:2] > 6'h11;
   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_reset_quiet: assert property (@(posedge clock) disable iff (1'b0)
      rst |=> !wb_ack_o && !irq && wb_dat_o == 32'h0)
      else $error("outputs not cleared by reset");
   a_ctrl_unused_zero: assert property (ctrl_rd |-> (wb_dat_o & ~32'h0000b8b6) == 32'h0)
      else $error("unused control bits read nonzero");
   a_wip_sync_zero: assert property (ctrl_rd && (!wb_dat_o[1] || wb_dat_o[2]) |-> !wb_dat_o[11])
      else $error("pending bit set in synchronous mode");
   a_hole_reads_zero: assert property (hole_rd |-> wb_dat_o == 32'h0)
      else $error("unmapped read nonzero");
   a_rdata_hold: assert property (!$past(rst) && $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
      else $error("read data changed outside a read");
   a_irq_drop_write: assert property (!$past(rst) && $fell(irq) |-> $past(wb_ack_o && wb_we_i))
      else $error("interrupt fell without a write");
   c_pending_seen: cover property (ctrl_rd && wb_dat_o[11]);
   c_irq_rise: cover property ($rose(irq));
   c_status_write: cover property (wb_ack_o && wb_we_i && wb_adr_i == 8'h40);
endmodule

bind aist_timer aist_timer_props aist_timer_props_i (.clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_pin(ext_clk_pin),
   .sosc_clk_pin(sosc_clk_pin), .gate_pin(gate_pin), .idle_mode(idle_mode),
   .sleep_mode(sleep_mode), .irq(irq));

// *** test/aist_timer_test.sv ***
`timescale 1ns/100ps
module aist_timer_test;
   logic clock, rst, cyc, stb, we, gate, idle, sleep, ext_run, sosc_run, ack, irq, ext_pin, sosc_pin;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r, q;
   int failures = 0;
   int checked = 0;
   int sh[4] = '{0, 3, 6, 8};
   localparam logic [7:0] CT = aist_pkg::ADR_CTRL;
   localparam logic [7:0] CN = aist_pkg::ADR_COUNT;
   localparam logic [7:0] PE = aist_pkg::ADR_PERIOD;
   localparam logic [7:0] MK = aist_pkg::ADR_MASK;
   localparam logic [7:0] ST = aist_pkg::ADR_STAT;
   localparam logic [7:0] CF = aist_pkg::ADR_CFG;

   aist_timer aist_timer_i (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
      .ext_clk_pin(ext_pin), .sosc_clk_pin(sosc_pin), .gate_pin(gate), .idle_mode(idle),
      .sleep_mode(sleep), .irq(irq));
   aist_clk_src #(.HALF(3)) aist_clk_src_i (.clock(clock), .run(ext_run), .pin(ext_pin));
   aist_clk_src #(.HALF(5)) aist_clk_src_sosc_i (.clock(clock), .run(sosc_run), .pin(sosc_pin));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // ----------------
   // Bus and checks
   // ----------------
   task automatic final_report;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // One classic cycle; the slave's latency is awaited, never assumed
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hf;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 16);
      q = dat_r;
      // Release now; the next call lets an idle cycle pass first
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 16) begin
         failures++;
         $display("[FAIL] ack expected 1 seen %b", ack);
         final_report();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Range check for counts whose phase depends on bus timing
   task automatic rng(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] g);
      checked++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         failures++;
         $display("[FAIL] %s expected %h..%h seen %h", nm, lo, hi, g);
      end
   endtask

   task automatic clk(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic wait_irq(input int lim);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge clock);
         n++;
      end
      chk("irq", 32'h1, {31'h0, irq});
      if (n >= lim) final_report();
   endtask

   // ----------------
   // Main sequence
   // ----------------
   initial begin
      rst = 1'b1;
      {cyc, stb, we, gate, idle, sleep, ext_run, sosc_run} = 8'h00;
      adr = 8'h00;
      sel = 4'h0;
      dat_w = 32'h0;
      clk(4);
      rst <= 1'b0;
      // Reset values and an unmapped hole
      rd(CT);
      chk("ctrl", 32'h0, q);
      rd(CN);
      chk("count", 32'h0, q);
      rd(PE);
      chk("period", 32'hffff, q);
      rd(ST);
      chk("status", 32'h0, q);
      rd(MK);
      chk("mask", 32'h0, q);
      rd(CF);
      chk("cfg", 32'h0, q);
      rd(8'h48);
      chk("hole", 32'h0, q);
      // Companion clear, set and invert
      wr(CT, 32'hffffffff);
      rd(CT);
      chk("ctrl all", 32'h0000b0b6, q);
      wr(CT + 8'h4, 32'h8000);
      rd(CT);
      chk("ctrl clr", 32'h000030b6, q);
      wr(CT + 8'h8, 32'h0040);
      rd(CT);
      chk("ctrl set", 32'h000030b6, q);
      wr(CT + 8'hc, 32'h0030);
      rd(CT);
      chk("ctrl inv", 32'h00003086, q);
      wr(CT + 8'h4, 32'hffffffff);
      wr(CN, 32'h00f0);
      wr(CN + 8'h8, 32'h000f);
      wr(CN + 8'h4, 32'h00f0);
      wr(CN + 8'hc, 32'h0003);
      rd(CN);
      chk("count ops", 32'h000c, q);
      // Prescale codes on the internal clock
      for (int p = 0; p < 4; p++) begin
         wr(CN, 32'h0);
         wr(CT, 32'h8000 | (p << 4));
         clk(2048);
         wr(CT, 32'h0);
         rd(CN);
         rng("prescaled", 2048 >> sh[p], (2048 >> sh[p]) + 4, q);
      end
      // Wrap at period, flag, mask and clear
      wr(PE, 32'h5);
      wr(CN, 32'h0);
      wr(MK, 32'h1);
      wr(CT, 32'h8000);
      wait_irq(40);
      rd(CN);
      rng("wrapped", 0, 5, q);
      wr(CT, 32'h0);
      wr(MK, 32'h0);
      clk(2);
      chk("irq masked", 32'h0, {31'h0, irq});
      rd(ST);
      chk("flag", 32'h1, q);
      wr(MK, 32'h1);
      wait_irq(4);
      wr(ST, 32'h1);
      clk(2);
      chk("irq cleared", 32'h0, {31'h0, irq});
      wr(PE, 32'hffff);
      // Idle with and without stop
      wr(CN, 32'h0);
      idle <= 1'b1;
      wr(CT, 32'ha000);
      clk(20);
      rd(CN);
      chk("idle stop", 32'h0, q);
      wr(CT, 32'h8000);
      clk(20);
      rd(CN);
      rng("idle run", 20, 30, q);
      // Sleep halts the bus-clocked modes even while idle would run
      sleep <= 1'b1;
      wr(CN, 32'h0);
      clk(20);
      rd(CN);
      chk("sleep stop", 32'h0, q);
      sleep <= 1'b0;
      idle <= 1'b0;
      // Gated accumulation
      wr(CT, 32'h0);
      wr(CN, 32'h0);
      wr(ST, 32'h3);
      wr(CT, 32'h8080);
      clk(20);
      rd(CN);
      chk("gate low", 32'h0, q);
      gate <= 1'b1;
      clk(40);
      gate <= 1'b0;
      clk(8);
      rd(CN);
      rng("gate high", 39, 41, q);
      rd(ST);
      chk("gate flag", 32'h1, q & 32'h1);
      wr(CT, 32'h8086);
      wr(ST, 32'h3);
      gate <= 1'b1;
      clk(20);
      gate <= 1'b0;
      clk(8);
      rd(ST);
      chk("gate ignored", 32'h0, q & 32'h1);
      // Asynchronous writes, blocked and legacy, counting in sleep
      wr(CT, 32'h0);
      wr(CT, 32'h9002);
      wr(CN, 32'h1234);
      rd(CT);
      chk("pending", 32'h9802, q);
      wr(CN, 32'h5555);
      rd(ST);
      chk("dropped", 32'h2, q & 32'h2);
      sleep <= 1'b1;
      ext_run <= 1'b1;
      clk(60);
      rd(CT);
      chk("write done", 32'h9002, q);
      rd(CN);
      rng("async count", 32'h1234, 32'h1240, q);
      ext_run <= 1'b0;
      sleep <= 1'b0;
      wr(ST, 32'h3);
      wr(CT, 32'h8002);
      wr(CN, 32'h0100);
      wr(CN, 32'h0200);
      rd(ST);
      chk("no drop", 32'h0, q & 32'h2);
      ext_run <= 1'b1;
      clk(60);
      rd(CN);
      rng("legacy", 32'h0200, 32'h020c, q);
      // Synchronised external clock
      ext_run <= 1'b0;
      wr(CT, 32'h8006);
      wr(CN, 32'h0300);
      rd(CT);
      chk("sync wip", 32'h8006, q);
      rd(CN);
      chk("sync load", 32'h0300, q);
      ext_run <= 1'b1;
      clk(60);
      rd(CN);
      rng("sync ext", 32'h0307, 32'h030c, q);
      // Secondary oscillator as the asynchronous source
      ext_run <= 1'b0;
      wr(CF, 32'h1);
      wr(CT, 32'h8002);
      wr(CN, 32'h0);
      sosc_run <= 1'b1;
      clk(100);
      rd(CN);
      rng("sosc", 5, 10, q);
      final_report();
   end
endmodule
